// >>> src/slc_pkg.sv
package slc_pkg;
  // ----------------------------------------
  // Line codes
  // ----------------------------------------
  localparam int          CODE_W      = 3;
  localparam logic [2:0]  CODE_NRZ    = 3'h0;
  localparam logic [2:0]  CODE_INV    = 3'h1;  // inverted_level_coding
  localparam logic [2:0]  CODE_NRZI_M = 3'h2;
  localparam logic [2:0]  CODE_NRZI_S = 3'h3;
  localparam logic [2:0]  CODE_BPM    = 3'h4;
  localparam logic [2:0]  CODE_BPS    = 3'h5;
  localparam logic [2:0]  CODE_BPL    = 3'h6;
  localparam logic [2:0]  CODE_DBL    = 3'h7;
  // ----------------------------------------
  // Clock sources
  // ----------------------------------------
  localparam int          SRC_W       = 4;
  localparam int          SRC_NUM     = 9;
  localparam logic [3:0]  SRC_OFF     = 4'h0;
  localparam logic [3:0]  SRC_BRG0    = 4'h1;
  localparam logic [3:0]  SRC_BRG1    = 4'h2;
  localparam logic [3:0]  SRC_CLOCK_RECOVERY_LOOP    = 4'h3;
  localparam logic [3:0]  SRC_TXPIN   = 4'h4;
  localparam logic [3:0]  SRC_RXPIN   = 4'h5;
  localparam logic [3:0]  SRC_AUX0    = 4'h6;
  localparam logic [3:0]  SRC_AUX1    = 4'h7;
  localparam logic [3:0]  SRC_PS0     = 4'h8;
  localparam logic [3:0]  SRC_PS1     = 4'h9;
  // ----------------------------------------
  // Baud rate generator, prescaler, loop
  // ----------------------------------------
  localparam int          TC_W        = 16;
  localparam int          PS_W        = 5;
  localparam int          PS_BIT_BASE = 1;     // Bit 1 divides by 4
  localparam int          DP_W        = 6;
  localparam logic [5:0]  DP_BASE_N   = 6'h08; // Rate 0 is 8x
  localparam logic [1:0]  DP_ADJ_NONE = 2'h0;
  localparam logic [1:0]  DP_ADJ_LONG = 2'h1;
  localparam logic [1:0]  DP_ADJ_SHORT = 2'h2;
  // ----------------------------------------
  // Time slot assigner
  // ----------------------------------------
  localparam int          TSA_SLOT_W  = 7;
  localparam int          TSA_NUM_W   = 4;
  localparam int          TSA_OFS_W   = 3;
  localparam int          TSA_BIT_W   = 11;
  localparam int          TSA_SLOT_LSB = 3;    // Eight bits per slot
  localparam logic        LINE_IDLE   = 1'b1;
endpackage

// >>> src/slc_brg.sv
`timescale 1ns/100ps
module slc_brg (
  input  wire logic                     ref_clk,
  input  wire logic                     srst,
  input  wire logic                     in_lvl,
  input  wire logic                     in_tick,
  input  wire logic                     enable,
  input  wire logic                     auto_reload,
  input  wire logic [slc_pkg::TC_W-1:0] tc,
  output logic                          out_q
);
  logic [slc_pkg::TC_W-1:0] cnt_q;
  logic [slc_pkg::TC_W-1:0] tcl_q;
  logic [slc_pkg::TC_W-1:0] nxt;
  logic [slc_pkg::TC_W-1:0] half;
  logic                     done_q;
  logic                     step;

  assign step = enable && in_tick && !done_q;
  assign nxt  = (cnt_q == '0) ? tc : cnt_q - 1'b1;
  // Rounded-up half keeps two toggles per period for odd constants
  assign half = slc_pkg::TC_W'((17'(tcl_q) + 17'h00001) >> 1);

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  // New constant only reaches the counter at a load
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cnt_q  <= '0;
      tcl_q  <= '0;
      done_q <= 1'b0;
    end else if (!enable) begin
      cnt_q  <= tc;
      tcl_q  <= tc;
      done_q <= 1'b0;
    end else if (step) begin
      if (cnt_q == '0) begin
        if (auto_reload) begin
          cnt_q <= tc;
          tcl_q <= tc;
        end else begin
          done_q <= 1'b1;
        end
      end else begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Output
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst || !enable) begin
      out_q <= 1'b0;
    end else if (tcl_q == '0) begin
      out_q <= in_lvl && !done_q;
    end else if (step && (cnt_q != '0 || auto_reload) && (nxt == '0 || nxt == half)) begin
      out_q <= ~out_q;
    end
  end

  property p_brg_reload;
    @(posedge ref_clk) disable iff (srst)
      (step && cnt_q == '0 && auto_reload) |=> (cnt_q == $past(tc) && tcl_q == $past(tc));
  endproperty
  a_brg_reload: assert property (p_brg_reload) else $error("reload missed");

  property p_brg_hold;
    @(posedge ref_clk) disable iff (srst)
      (enable && !in_tick && $past(enable)) |=> $stable(cnt_q);
  endproperty
  a_brg_hold: assert property (p_brg_hold) else $error("counter moved without tick");

  property p_brg_toggle;
    @(posedge ref_clk) disable iff (srst)
      (step && tcl_q != '0 && cnt_q == 16'h0001) |=> (out_q != $past(out_q));
  endproperty
  a_brg_toggle: assert property (p_brg_toggle) else $error("no toggle at zero");
endmodule

// >>> src/slc_line_top.sv
`timescale 1ns/100ps
module slc_line_top (
  input  wire logic                          ref_clk,
  input  wire logic                          srst,
  input  wire logic                          rxd_pin,
  input  wire logic                          tx_clock_pin_i,
  input  wire logic                          rx_clock_pin_i,
  input  wire logic                          aux_pin_zero,
  input  wire logic                          aux_pin_one,
  input  wire logic                          frame_sync,
  input  wire logic                          tx_bit,
  input  wire logic [slc_pkg::CODE_W-1:0]    tx_code,
  input  wire logic [slc_pkg::CODE_W-1:0]    rx_code,
  input  wire logic [slc_pkg::SRC_W-1:0]     tx_clk_src,
  input  wire logic [slc_pkg::SRC_W-1:0]     rx_clk_src,
  input  wire logic [slc_pkg::SRC_W-1:0]     tx_pin_out_src,
  input  wire logic [slc_pkg::SRC_W-1:0]     rx_pin_out_src,
  input  wire logic [slc_pkg::SRC_W-1:0]     brg0_src,
  input  wire logic [slc_pkg::SRC_W-1:0]     brg1_src,
  input  wire logic [slc_pkg::SRC_W-1:0]     clock_recovery_loop_src,
  input  wire logic [1:0]                    brg_enable,
  input  wire logic [1:0]                    brg_auto_reload,
  input  wire logic [slc_pkg::TC_W-1:0]      brg0_tc,
  input  wire logic [slc_pkg::TC_W-1:0]      brg1_tc,
  input  wire logic [1:0]                    ps_in_sel,
  input  wire logic [1:0]                    ps0_div,
  input  wire logic [1:0]                    ps1_div,
  input  wire logic [1:0]                    clock_recovery_loop_rate,
  input  wire logic                          tsa_enable,
  input  wire logic [slc_pkg::TSA_SLOT_W-1:0] tsa_first_slot,
  input  wire logic [slc_pkg::TSA_NUM_W-1:0] tsa_num_slots,
  input  wire logic [slc_pkg::TSA_OFS_W-1:0] tsa_offset,
  input  wire logic                          local_loopback,
  input  wire logic                          auto_echo,
  output logic                               txd_q,
  output logic                               tx_clock_pin_o_q,
  output logic                               tx_clock_pin_oe_q,
  output logic                               rx_clock_pin_o_q,
  output logic                               rx_clock_pin_oe_q,
  output logic                               tx_bit_take_q,
  output logic                               rx_bit_q,
  output logic                               rx_bit_valid_q,
  output logic                               tsa_gate_q,
  output logic                               clock_recovery_loop_clk_q
);
  // ----------------------------------------
  // Clock selection
  // ----------------------------------------
  function automatic logic sel_clk(input logic [slc_pkg::SRC_W-1:0] src,
                                   input logic [slc_pkg::SRC_NUM-1:0] lvls);
    logic r;
    r = 1'b0;
    if (src != slc_pkg::SRC_OFF && src <= slc_pkg::SRC_W'(slc_pkg::SRC_NUM)) begin
      r = lvls[src - 4'h1];
    end
    return r;
  endfunction

  logic [1:0]                  brg_out;
  logic [slc_pkg::PS_W-1:0]    ps0_cnt_q;
  logic [slc_pkg::PS_W-1:0]    ps1_cnt_q;
  logic                        ps0_lvl;
  logic                        ps1_lvl;
  logic [slc_pkg::SRC_NUM-1:0] lvls;
  logic                        tx_lvl;
  logic                        rx_lvl;
  logic                        b0_lvl;
  logic                        b1_lvl;
  logic                        dp_lvl;
  logic                        tx_prev_q;
  logic                        rx_prev_q;
  logic                        b0_prev_q;
  logic                        b1_prev_q;
  logic                        dp_prev_q;
  logic                        ps_prev_q;
  logic                        tx_rise;
  logic                        tx_fall;
  logic                        rx_rise;
  logic                        rx_fall;

  assign ps0_lvl = ps0_cnt_q[slc_pkg::PS_BIT_BASE + int'(ps0_div)];
  assign ps1_lvl = ps1_cnt_q[slc_pkg::PS_BIT_BASE + int'(ps1_div)];
  assign lvls    = {ps1_lvl, ps0_lvl, aux_pin_one, aux_pin_zero, rx_clock_pin_i,
                    tx_clock_pin_i, clock_recovery_loop_clk_q, brg_out};
  assign tx_lvl  = sel_clk(tx_clk_src, lvls);
  assign rx_lvl  = sel_clk(rx_clk_src, lvls);
  assign b0_lvl  = sel_clk(brg0_src, lvls);
  assign b1_lvl  = sel_clk(brg1_src, lvls);
  assign dp_lvl  = sel_clk(clock_recovery_loop_src, lvls);
  assign tx_rise = tx_lvl && !tx_prev_q;
  assign tx_fall = !tx_lvl && tx_prev_q;
  assign rx_rise = rx_lvl && !rx_prev_q;
  assign rx_fall = !rx_lvl && rx_prev_q;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tx_prev_q <= 1'b0;
      rx_prev_q <= 1'b0;
      b0_prev_q <= 1'b0;
      b1_prev_q <= 1'b0;
      dp_prev_q <= 1'b0;
    end else begin
      tx_prev_q <= tx_lvl;
      rx_prev_q <= rx_lvl;
      b0_prev_q <= b0_lvl;
      b1_prev_q <= b1_lvl;
      dp_prev_q <= dp_lvl;
    end
  end

  // Pin drivers: enable only while a source is picked
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tx_clock_pin_o_q  <= 1'b0;
      tx_clock_pin_oe_q <= 1'b0;
      rx_clock_pin_o_q  <= 1'b0;
      rx_clock_pin_oe_q <= 1'b0;
    end else begin
      tx_clock_pin_o_q  <= sel_clk(tx_pin_out_src, lvls);
      tx_clock_pin_oe_q <= tx_pin_out_src != slc_pkg::SRC_OFF;
      rx_clock_pin_o_q  <= sel_clk(rx_pin_out_src, lvls);
      rx_clock_pin_oe_q <= rx_pin_out_src != slc_pkg::SRC_OFF;
    end
  end

  // ----------------------------------------
  // Prescalers
  // ----------------------------------------
  // Both share one edge detector on the chosen aux pin
  logic ps_in;
  assign ps_in = ps_in_sel[0] ? aux_pin_one : aux_pin_zero;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ps_prev_q <= 1'b0;
      ps0_cnt_q <= '0;
      ps1_cnt_q <= '0;
    end else begin
      ps_prev_q <= ps_in;
      if (ps_in && !ps_prev_q) begin
        ps0_cnt_q <= ps0_cnt_q + 1'b1;
        if (ps_in_sel[1]) begin
          ps1_cnt_q <= ps1_cnt_q + 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // Baud rate generators
  // ----------------------------------------
  slc_brg u_brg0 (
    .ref_clk     (ref_clk),
    .srst        (srst),
    .in_lvl      (b0_lvl),
    .in_tick     (b0_lvl && !b0_prev_q),
    .enable      (brg_enable[0]),
    .auto_reload (brg_auto_reload[0]),
    .tc          (brg0_tc),
    .out_q       (brg_out[0])
  );
  slc_brg u_brg1 (
    .ref_clk     (ref_clk),
    .srst        (srst),
    .in_lvl      (b1_lvl),
    .in_tick     (b1_lvl && !b1_prev_q),
    .enable      (brg_enable[1]),
    .auto_reload (brg_auto_reload[1]),
    .tc          (brg1_tc),
    .out_q       (brg_out[1])
  );

  // ----------------------------------------
  // Clock recovery loop
  // ----------------------------------------
  logic                     rx_line;
  logic                     rx_line_prev_q;
  logic [slc_pkg::DP_W-1:0] dp_n;
  logic [slc_pkg::DP_W-1:0] dp_lim;
  logic [slc_pkg::DP_W-1:0] dp_cnt_q;
  logic [1:0]               dp_adj_q;

  assign rx_line = local_loopback ? txd_q : rxd_pin;
  assign dp_n    = slc_pkg::DP_BASE_N << clock_recovery_loop_rate;
  assign dp_lim  = (dp_adj_q == slc_pkg::DP_ADJ_LONG)  ? dp_n :
                   (dp_adj_q == slc_pkg::DP_ADJ_SHORT) ? dp_n - 6'h02 : dp_n - 6'h01;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      dp_cnt_q       <= '0;
      dp_adj_q       <= slc_pkg::DP_ADJ_NONE;
      clock_recovery_loop_clk_q     <= 1'b0;
      rx_line_prev_q <= slc_pkg::LINE_IDLE;
    end else begin
      rx_line_prev_q <= rx_line;
      if (dp_lvl && !dp_prev_q) begin
        if (dp_cnt_q >= dp_lim) begin
          dp_cnt_q <= '0;
          dp_adj_q <= slc_pkg::DP_ADJ_NONE;
        end else begin
          dp_cnt_q <= dp_cnt_q + 1'b1;
        end
        clock_recovery_loop_clk_q <= dp_cnt_q < (dp_n >> 1);
      end
      // Late edge lengthens, early edge shortens, the current cycle only
      if (rx_line != rx_line_prev_q && dp_cnt_q != '0 && clock_recovery_loop_src != slc_pkg::SRC_OFF) begin
        dp_adj_q <= (dp_cnt_q < (dp_n >> 1)) ? slc_pkg::DP_ADJ_LONG : slc_pkg::DP_ADJ_SHORT;
      end
    end
  end

  // ----------------------------------------
  // Encoder
  // ----------------------------------------
  logic enc_q;
  logic dbl_dir_q;
  logic enc_d;
  logic dbl_dir_d;

  always_comb begin
    enc_d     = enc_q;
    dbl_dir_d = dbl_dir_q;
    if (tx_rise) begin
      case (tx_code)
        slc_pkg::CODE_NRZ:    enc_d = tx_bit;
        slc_pkg::CODE_INV:    enc_d = !tx_bit;
        slc_pkg::CODE_NRZI_M: enc_d = enc_q ^ tx_bit;
        slc_pkg::CODE_NRZI_S: enc_d = enc_q ^ !tx_bit;
        slc_pkg::CODE_BPM:    enc_d = !enc_q;
        slc_pkg::CODE_BPS:    enc_d = !enc_q;
        slc_pkg::CODE_BPL:    enc_d = tx_bit;
        slc_pkg::CODE_DBL: begin
          dbl_dir_d = enc_q ^ tx_bit;
          enc_d     = !(enc_q ^ tx_bit);
        end
        default:              enc_d = enc_q;
      endcase
    end else if (tx_fall) begin
      case (tx_code)
        slc_pkg::CODE_BPM: enc_d = enc_q ^ tx_bit;
        slc_pkg::CODE_BPS: enc_d = enc_q ^ !tx_bit;
        slc_pkg::CODE_BPL: enc_d = !enc_q;
        slc_pkg::CODE_DBL: enc_d = dbl_dir_q;
        default:           enc_d = enc_q;
      endcase
    end
  end

  // Bit must stay steady through the cell for mid-cell codes
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      enc_q         <= slc_pkg::LINE_IDLE;
      dbl_dir_q     <= 1'b0;
      tx_bit_take_q <= 1'b0;
      txd_q         <= slc_pkg::LINE_IDLE;
    end else begin
      enc_q         <= enc_d;
      dbl_dir_q     <= dbl_dir_d;
      tx_bit_take_q <= tx_rise;
      txd_q         <= auto_echo ? rxd_pin : enc_d;
    end
  end

  // ----------------------------------------
  // Decoder and slot window
  // ----------------------------------------
  logic                          h1_q;
  logic                          h2_prev_q;
  logic                          dec;
  logic [slc_pkg::TSA_BIT_W-1:0] tsa_bit_q;
  logic [slc_pkg::TSA_OFS_W-1:0] tsa_dly_q;
  logic                          fs_prev_q;
  logic                          in_win;
  logic [slc_pkg::TSA_BIT_W-1:0] slot;

  always_comb begin
    case (rx_code)
      slc_pkg::CODE_NRZ:    dec = rx_line;
      slc_pkg::CODE_INV:    dec = !rx_line;
      slc_pkg::CODE_NRZI_M: dec = rx_line ^ h2_prev_q;
      slc_pkg::CODE_NRZI_S: dec = !(rx_line ^ h2_prev_q);
      slc_pkg::CODE_BPM:    dec = h1_q ^ rx_line;
      slc_pkg::CODE_BPS:    dec = !(h1_q ^ rx_line);
      slc_pkg::CODE_BPL:    dec = h1_q;
      slc_pkg::CODE_DBL:    dec = rx_line ^ h2_prev_q;
      default:              dec = rx_line;
    endcase
  end

  assign slot   = tsa_bit_q >> slc_pkg::TSA_SLOT_LSB;
  assign in_win = tsa_dly_q == '0 && tsa_num_slots != '0 &&
                  slot >= slc_pkg::TSA_BIT_W'(tsa_first_slot) &&
                  slot < slc_pkg::TSA_BIT_W'(tsa_first_slot) + slc_pkg::TSA_BIT_W'(tsa_num_slots);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      h1_q           <= slc_pkg::LINE_IDLE;
      h2_prev_q      <= slc_pkg::LINE_IDLE;
      rx_bit_q       <= 1'b0;
      rx_bit_valid_q <= 1'b0;
    end else begin
      rx_bit_valid_q <= rx_rise && (!tsa_enable || in_win);
      if (rx_fall) begin
        h1_q <= rx_line;
      end
      if (rx_rise) begin
        h2_prev_q <= rx_line;
        rx_bit_q  <= dec;
      end
    end
  end

  // Slot position counted in receive bit cells after the delay
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      fs_prev_q  <= 1'b0;
      tsa_bit_q  <= '0;
      tsa_dly_q  <= '0;
      tsa_gate_q <= 1'b0;
    end else begin
      fs_prev_q  <= frame_sync;
      tsa_gate_q <= tsa_enable && in_win;
      if (frame_sync && !fs_prev_q) begin
        tsa_bit_q <= '0;
        tsa_dly_q <= tsa_offset;
      end else if (rx_rise) begin
        if (tsa_dly_q != '0) begin
          tsa_dly_q <= tsa_dly_q - 1'b1;
        end else if (tsa_bit_q != '1) begin
          tsa_bit_q <= tsa_bit_q + 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_tx_off;
    tx_clk_src == slc_pkg::SRC_OFF ##1 tx_clk_src == slc_pkg::SRC_OFF;
  endsequence
  property p_tx_off;
    @(posedge ref_clk) disable iff (srst) s_tx_off |=> !tx_bit_take_q;
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("transmit clock ran while off");

  property p_nrz;
    @(posedge ref_clk) disable iff (srst)
      (tx_rise && tx_code == slc_pkg::CODE_NRZ && !auto_echo) |=> (txd_q == $past(tx_bit));
  endproperty
  a_nrz: assert property (p_nrz) else $error("plain level wrong");

  property p_inv;
    @(posedge ref_clk) disable iff (srst)
      (tx_rise && tx_code == slc_pkg::CODE_INV && !auto_echo) |=> (txd_q != $past(tx_bit));
  endproperty
  a_inv: assert property (p_inv) else $error("inverted level wrong");

  property p_nrzi_m;
    @(posedge ref_clk) disable iff (srst)
      (tx_rise && tx_code == slc_pkg::CODE_NRZI_M) |=> (enc_q == ($past(enc_q) ^ $past(tx_bit)));
  endproperty
  a_nrzi_m: assert property (p_nrzi_m) else $error("mark inversion wrong");

  property p_bpm_start;
    @(posedge ref_clk) disable iff (srst)
      (tx_rise && tx_code == slc_pkg::CODE_BPM) |=> (enc_q != $past(enc_q));
  endproperty
  a_bpm_start: assert property (p_bpm_start) else $error("no cell start edge");

  property p_bpl_mid;
    @(posedge ref_clk) disable iff (srst)
      (tx_fall && tx_code == slc_pkg::CODE_BPL) |=> (enc_q == !$past(tx_bit));
  endproperty
  a_bpl_mid: assert property (p_bpl_mid) else $error("biphase level half wrong");

  property p_echo;
    @(posedge ref_clk) disable iff (srst) auto_echo |=> (txd_q == $past(rxd_pin));
  endproperty
  a_echo: assert property (p_echo) else $error("echo path broken");

  property p_dp_range;
    @(posedge ref_clk) disable iff (srst) dp_cnt_q <= (dp_n + 6'h01);
  endproperty
  a_dp_range: assert property (p_dp_range) else $error("loop count out of range");

  property p_gate;
    @(posedge ref_clk) disable iff (srst) rx_bit_valid_q && tsa_enable |-> $past(in_win);
  endproperty
  a_gate: assert property (p_gate) else $error("bit outside slot window");
endmodule

// >>> tb/slc_line_partner.sv
`timescale 1ns/100ps
// ----
// Line partner: tx clock pin stands still unless run
// ----
module slc_line_partner (
  input  wire logic ref_clk,
  input  wire logic clk_run,
  input  wire logic aux_run,
  input  wire logic rxd_lvl,
  output logic      tx_clock_pin_i,
  output logic      aux_pin_zero,
  output logic      rxd_pin
);
  int ph = 0;
  initial {tx_clock_pin_i, aux_pin_zero, rxd_pin} = 3'h1;
  // Phase restarts so a fresh run never opens with a short cell
  always @(posedge ref_clk) begin
    ph <= clk_run ? (ph + 1) % 12 : 0;
    tx_clock_pin_i <= clk_run && ph < 6;
    aux_pin_zero <= aux_run ? ~aux_pin_zero : 1'b0;
    rxd_pin <= rxd_lvl;
  end
endmodule

// >>> tb/slc_line_top_test.sv
`timescale 1ns/100ps
module slc_line_top_test;
  // ----
  // Stimulus and observation
  // ----
  logic                           ref_clk, srst, rxd_pin, tx_clock_pin_i, aux_pin_zero, aux_pin_one, frame_sync;
  logic                           tx_bit, tsa_enable, local_loopback, auto_echo, clk_run, aux_run, rxd_lvl, prev;
  logic [slc_pkg::CODE_W-1:0]     tx_code, rx_code;
  logic [slc_pkg::SRC_W-1:0]      tx_clk_src, rx_clk_src, tx_pin_out_src, rx_pin_out_src, brg0_src, brg1_src, clock_recovery_loop_src;
  logic [1:0]                     brg_enable, brg_auto_reload, ps_in_sel, ps0_div, ps1_div, clock_recovery_loop_rate, ex;
  logic [slc_pkg::TC_W-1:0]       brg0_tc, brg1_tc;
  logic [slc_pkg::TSA_SLOT_W-1:0] tsa_first_slot;
  logic [slc_pkg::TSA_NUM_W-1:0]  tsa_num_slots;
  logic [slc_pkg::TSA_OFS_W-1:0]  tsa_offset;
  logic                           txd_q, tx_clock_pin_o_q, tx_clock_pin_oe_q, rx_clock_pin_o_q, rx_clock_pin_oe_q;
  logic                           tx_bit_take_q, rx_bit_q, rx_bit_valid_q, tsa_gate_q, clock_recovery_loop_clk_q;
  logic [7:0]                     pat;
  int                             errors = 0, tests_run = 0, cyc = 0, t0;

  // Receive clock pin shares the partner's transmit clock
  slc_line_top uut (
    .ref_clk, .srst, .rxd_pin, .tx_clock_pin_i, .rx_clock_pin_i(tx_clock_pin_i), .aux_pin_zero, .aux_pin_one,
    .frame_sync, .tx_bit, .tx_code, .rx_code, .tx_clk_src, .rx_clk_src, .tx_pin_out_src, .rx_pin_out_src,
    .brg0_src, .brg1_src, .clock_recovery_loop_src, .brg_enable, .brg_auto_reload, .brg0_tc, .brg1_tc, .ps_in_sel, .ps0_div,
    .ps1_div, .clock_recovery_loop_rate, .tsa_enable, .tsa_first_slot, .tsa_num_slots, .tsa_offset, .local_loopback,
    .auto_echo, .txd_q, .tx_clock_pin_o_q, .tx_clock_pin_oe_q, .rx_clock_pin_o_q, .rx_clock_pin_oe_q,
    .tx_bit_take_q, .rx_bit_q, .rx_bit_valid_q, .tsa_gate_q, .clock_recovery_loop_clk_q
  );
  slc_line_partner peer (.ref_clk, .clk_run, .aux_run, .rxd_lvl, .tx_clock_pin_i, .aux_pin_zero, .rxd_pin);

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      stop_test();
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  function automatic logic pick(input int w);
    case (w)
      0:       return tx_bit_take_q;
      1:       return tx_clock_pin_o_q;
      2:       return rx_clock_pin_o_q;
      default: return clock_recovery_loop_clk_q;
    endcase
  endfunction
  task automatic wait_for(input int w, input logic lvl);
    int n;
    n = 0;
    @(negedge ref_clk);
    while (pick(w) !== lvl && n < 200) begin
      @(negedge ref_clk);
      n++;
    end
    if (pick(w) !== lvl) begin
      errors++;
      stop_test();
    end
  endtask
  // Two warm-up periods let a new setting settle before timing
  task automatic period(input int w, input int exp, input string what);
    for (int k = 0; k < 3; k++) begin
      wait_for(w, 1'b0);
      wait_for(w, 1'b1);
      if (k == 1) t0 = cyc;
    end
    check(what, 16'(cyc - t0), 16'(exp));
  endtask
  // Returns {first half, second half} from bit and previous line level
  function automatic logic [1:0] enc(input logic [2:0] c, input logic b, input logic p);
    case (c)
      slc_pkg::CODE_NRZ:    return {b, b};
      slc_pkg::CODE_INV:    return {~b, ~b};
      slc_pkg::CODE_NRZI_M: return {2{p ^ b}};
      slc_pkg::CODE_NRZI_S: return {2{~(p ^ b)}};
      slc_pkg::CODE_BPM:    return {~p, p ^ ~b};
      slc_pkg::CODE_BPS:    return {~p, p ^ b};
      slc_pkg::CODE_BPL:    return {b, ~b};
      default:              return {~(p ^ b), p ^ b};
    endcase
  endfunction

  initial begin
    {frame_sync, tx_bit, tsa_enable, local_loopback, auto_echo, clk_run, aux_run, aux_pin_one, prev} = '0;
    {tx_code, rx_code, tx_clk_src, rx_clk_src, tx_pin_out_src, rx_pin_out_src, brg0_src, brg1_src, clock_recovery_loop_src} = '0;
    {brg_enable, brg_auto_reload, ps_in_sel, ps0_div, ps1_div, clock_recovery_loop_rate} = '0;
    {brg0_tc, brg1_tc, tsa_first_slot, tsa_num_slots, tsa_offset} = '0;
    {srst, rxd_lvl, pat} = {2'h3, 8'h4D};
    repeat (4) @(negedge ref_clk);
    srst = 1'b0;
    check("txd_reset", txd_q, 1'b1);
    check("oe_reset", tx_clock_pin_oe_q, 1'b0);
    clk_run = 1'b1;
    repeat (30) @(negedge ref_clk);
    check("take_off", tx_bit_take_q, 1'b0);
    check("txd_off", txd_q, 1'b1);
    {clk_run, tx_bit, prev} = {1'b0, pat[0], slc_pkg::LINE_IDLE};
    {tx_clk_src, rx_clk_src, local_loopback} = {slc_pkg::SRC_TXPIN, slc_pkg::SRC_RXPIN, 1'b1};
    @(negedge ref_clk);
    clk_run = 1'b1;
    for (int c = 0; c < 8; c++) begin
      for (int i = 0; i < 8; i++) begin
        wait_for(0, 1'b1);
        ex = enc(tx_code, pat[i], prev);
        if (i > 1) begin
          check("rx_valid", rx_bit_valid_q, 1'b1);
          check("rx_bit", rx_bit_q, pat[i-1]);
        end
        repeat (3) @(negedge ref_clk);
        check("txd_first_half", txd_q, ex[1]);
        repeat (6) @(negedge ref_clk);
        check("txd_second_half", txd_q, ex[0]);
        {prev, tx_bit} = {ex[0], pat[(i+1)%8]};
        if (i == 7) {tx_code, rx_code} = {2{3'(c + 1)}};
      end
    end
    {clk_run, tx_clk_src, local_loopback, auto_echo} = {1'b0, slc_pkg::SRC_OFF, 1'b0, 1'b1};
    for (int v = 0; v < 3; v++) begin
      rxd_lvl = v[0];
      repeat (4) @(negedge ref_clk);
      check("echo", txd_q, v[0]);
    end
    auto_echo = 1'b0;
    {aux_run, brg0_src, tx_pin_out_src, brg_enable, brg_auto_reload, brg0_tc} =
      {1'b1, slc_pkg::SRC_AUX0, slc_pkg::SRC_BRG0, 2'h1, 2'h3, 16'h0003};
    period(1, 8, "brg0_period");
    check("tx_pin_oe", tx_clock_pin_oe_q, 1'b1);
    brg0_tc = 16'h0007;
    period(1, 16, "brg0_new_tc");
    rx_pin_out_src = slc_pkg::SRC_PS0;
    for (int d = 0; d < 4; d++) begin
      ps0_div = d[1:0];
      period(2, 8 << d, "prescaler");
    end
    {ps0_div, brg1_src, rx_pin_out_src, brg_enable, brg1_tc} =
      {2'h0, slc_pkg::SRC_PS0, slc_pkg::SRC_BRG1, 2'h3, 16'h0001};
    period(2, 16, "brg1_period");
    clock_recovery_loop_src = slc_pkg::SRC_AUX0;
    for (int r = 0; r < 3; r++) begin
      clock_recovery_loop_rate = r[1:0];
      period(3, 16 << r, "recovered_clock");
    end
    // Two cells of offset, then slot 1 of eight bits: rises 11 to 18
    {tx_clk_src, tsa_enable, tsa_first_slot, tsa_num_slots, tsa_offset, frame_sync} =
      {slc_pkg::SRC_TXPIN, 1'b1, 7'h01, 4'h1, 3'h2, 1'b1};
    @(negedge ref_clk);
    {frame_sync, clk_run} = 2'h1;
    for (int k = 1; k < 21; k++) begin
      wait_for(0, 1'b1);
      check("tsa_valid", rx_bit_valid_q, 16'(k > 10 && k < 19));
      check("tsa_gate", tsa_gate_q, 16'(k > 10 && k < 19));
    end
    stop_test();
  end
endmodule
